// >>> src/wdt_top.sv
// Watchdog reset timer with classic Wishbone register slave
//
// Functional notes
// - Inhibit bits 7,5,3,1 read 1; protected bit written only when inhibit is 0.
// - Control bit 6 gates counter writes; reset value 0 blocks them.
// - Control bit 4 gates writes to control bits 2 and 0.
// - Watchdog-on set or cleared only with bit 4 set and inhibit 0.
// - Counter counts while watchdog-on is 1, stops when it is 0.
// - Reset flag set on overflow reset; cleared by pin or guarded 0 write.
// - Overflow reset clears only control bits 6,4,2, counter, standby, clock select and prescalers.
// - Eight-bit readable, writable up-counter, zero after reset.
// - Wrap from ff to 00 raises internal reset and sets the flag.
// - Clock select 0 picks system clock/8192, 1 picks sub clock/32.
// - Internal reset starts one reference clock after the overflowing tick.
// - Internal reset pulse lasts 512 oscillator clock cycles.
// - Counter resumes from written value, period 1 to 256 ticks.
// - Module standby bit 0 halts the watchdog; 1 releases, reset value.
// - Standby written while on is stored, takes effect once on clears.
// - Counter halts in watch, subsleep, standby; subactive needs sub clock.
`timescale 1ns/10ps
module wdt_top #(
  parameter int unsigned SYS_DIV    = wdt_pkg::SYS_DIV_DEF,
  parameter int unsigned SUB_DIV    = wdt_pkg::SUB_DIV_DEF,
  parameter int unsigned RST_CYCLES = wdt_pkg::RST_CYCLES_DEF
) (
  // Clock and external reset pin
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Reference ticks and power mode
  input  wire logic        sub_tick_i,
  input  wire logic        osc_tick_i,
  input  wire logic [2:0]  pmode_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // Chip reset and interrupt
  output logic             wdt_rst_o,
  output logic             irq_o
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  localparam int unsigned PW = (RST_CYCLES < 2) ? 1 : $clog2(RST_CYCLES);

  generate
    if (RST_CYCLES < 1) begin : g_bad_rst
      $error("wdt_top: RST_CYCLES must be at least 1");
    end
    // Prescalers need at least two source ticks per output tick
    if (SYS_DIV < 2) begin : g_bad_sys
      $error("wdt_top: SYS_DIV must be at least 2");
    end
    if (SUB_DIV < 2) begin : g_bad_sub
      $error("wdt_top: SUB_DIV must be at least 2");
    end
    // Pulse counter kept to a sane width
    if (PW > 16) begin : g_big_rst
      $error("wdt_top: RST_CYCLES must fit in 16 bits");
    end
  endgenerate

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a[7:2] == o[7:2];
  endfunction

  function automatic logic mode_runs(input logic [2:0] m, input logic ck);
    logic r;
    r = 1'b0;
    case (m)
      wdt_pkg::PM_ACTIVE:   r = 1'b1;
      wdt_pkg::PM_SLEEP:    r = 1'b1;
      wdt_pkg::PM_SUBACT:   r = ck;
      wdt_pkg::PM_WATCH:    r = 1'b0;
      wdt_pkg::PM_SUBSLEEP: r = 1'b0;
      wdt_pkg::PM_STANDBY:  r = 1'b0;
      default:              r = 1'b0;
    endcase
    return r;
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  wdt_pkg::wdt_state_e        st_q, st_d;
  logic [PW-1:0]              pcnt_q, pcnt_d;
  logic                       cnt_wen_q;
  logic                       ctrl_wen_q;
  logic                       wd_on_q;
  logic                       flag_q, flag_d;
  logic [7:0]                 cnt_q, cnt_d;
  logic                       mstby_q;
  logic                       cksel_q;
  logic [wdt_pkg::IRQ_W-1:0]  ists_q, ists_d;
  logic [wdt_pkg::IRQ_W-1:0]  imsk_q, imsk_d;
  logic                       ack_q;
  logic [31:0]                dat_q;
  logic                       watchdog_reset_flag_q;
  logic                       irq_q;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire       req      = cyc_i & stb_i & ~ack_q;
  wire       wr       = req & we_i & sel_i[0];
  wire       rd       = req & ~we_i;
  wire       hit_ctrl = hit(adr_i, wdt_pkg::OFS_CTRL);
  wire       hit_cnt  = hit(adr_i, wdt_pkg::OFS_CNT);
  wire       hit_mcs2 = hit(adr_i, wdt_pkg::OFS_MCS2);
  wire       hit_pfs3 = hit(adr_i, wdt_pkg::OFS_PFS3);
  wire       hit_ists = hit(adr_i, wdt_pkg::OFS_ISTS);
  wire       hit_imsk = hit(adr_i, wdt_pkg::OFS_IMSK);
  wire [7:0] wd       = dat_i[7:0];
  wire       ctrl_wr  = wr & hit_ctrl;

  // Internal reset clears only control bits 6,4,2, counter, standby, clock select and prescalers
  wire       pulse_on = (st_q == wdt_pkg::WDT_PULSE);
  wire       chip_rst = rst_i | pulse_on;

  // ****************************************************************
  // Control register write qualifiers
  // ****************************************************************
  wire cnt_wen_upd  = ctrl_wr & ~wd[wdt_pkg::BIT_CNT_WEN_INH];
  wire ctrl_wen_upd = ctrl_wr & ~wd[wdt_pkg::BIT_CTRL_WEN_INH];
  // Enable taken from before the write: one write cannot unlock itself
  wire wd_on_upd    = ctrl_wr & ctrl_wen_q
                    & ~wd[wdt_pkg::BIT_WD_ON_INH];
  wire flag_clr     = ctrl_wr & ctrl_wen_q
                    & ~wd[wdt_pkg::BIT_FLAG_INH]
                    & ~wd[wdt_pkg::BIT_FLAG];

  // ****************************************************************
  // Count clock selection and gating
  // ****************************************************************
  logic sys_tick;
  logic sub_tick;

  wdt_prescaler #(
    .DIV (SYS_DIV)
  ) u_sys_div (
    .clk_i  (clk_i),
    .rst_i  (chip_rst),
    .tick_i (1'b1),
    .tick_o (sys_tick)
  );

  wdt_prescaler #(
    .DIV (SUB_DIV)
  ) u_sub_div (
    .clk_i  (clk_i),
    .rst_i  (chip_rst),
    .tick_i (sub_tick_i),
    .tick_o (sub_tick)
  );

  wire in_tick  = cksel_q ? sub_tick : sys_tick;
  wire standby  = ~mstby_q & ~wd_on_q;
  wire runs     = mode_runs(pmode_i, cksel_q);
  wire cnt_inc  = wd_on_q & ~standby & runs & in_tick;
  wire cnt_wr   = wr & hit_cnt & cnt_wen_q;
  wire cnt_rej  = wr & hit_cnt & ~cnt_wen_q;
  wire overflow = cnt_inc & ~cnt_wr & (cnt_q == 8'hff);

  // Counter write beats an increment in the same cycle
  assign cnt_d = cnt_wr  ? wd :
                 cnt_inc ? cnt_q + 8'h01 :
                 cnt_q;

  // ****************************************************************
  // Internal reset generator
  // ****************************************************************
  wire ref_tick  = cksel_q ? sub_tick_i : 1'b1;
  wire flag_set  = (st_q == wdt_pkg::WDT_WAIT) & ref_tick;
  wire pulse_end = osc_tick_i & (pcnt_q == PW'(RST_CYCLES - 1));

  always_comb begin
    st_d   = st_q;
    pcnt_d = pcnt_q;
    case (st_q)
      wdt_pkg::WDT_IDLE: begin
        if (overflow) begin
          st_d = wdt_pkg::WDT_WAIT;
        end
      end
      wdt_pkg::WDT_WAIT: begin
        if (ref_tick) begin
          st_d   = wdt_pkg::WDT_PULSE;
          pcnt_d = '0;
        end
      end
      wdt_pkg::WDT_PULSE: begin
        if (pulse_end) begin
          st_d = wdt_pkg::WDT_IDLE;
        end else if (osc_tick_i) begin
          pcnt_d = pcnt_q + PW'(1);
        end
      end
      default: begin
        st_d = wdt_pkg::WDT_IDLE;
      end
    endcase
  end

  // Flag survives the internal reset; set wins over clear
  assign flag_d = flag_set | (flag_q & ~flag_clr);

  // ****************************************************************
  // Interrupt status and mask
  // ****************************************************************
  wire [wdt_pkg::IRQ_W-1:0] ev = {cnt_rej, flag_set};
  wire                      ists_clr = rd & hit_ists;

  assign ists_d = ev | (ists_q & {wdt_pkg::IRQ_W{~ists_clr}});
  assign imsk_d = (wr & hit_imsk) ? wd[wdt_pkg::IRQ_W-1:0] : imsk_q;

  // ****************************************************************
  // Read data
  // ****************************************************************
  wire [7:0] ctrl_rd = {1'b1, cnt_wen_q, 1'b1, ctrl_wen_q,
                        1'b1, wd_on_q,   1'b1, flag_q};
  wire [7:0] mcs2_rd = {5'h1f, mstby_q, 2'h3};
  wire [7:0] pfs3_rd = {2'h0, cksel_q, 5'h00};
  wire [7:0] ists_rd = {{(8 - wdt_pkg::IRQ_W){1'b0}}, ists_q};
  wire [7:0] imsk_rd = {{(8 - wdt_pkg::IRQ_W){1'b0}}, imsk_q};
  wire [7:0] rdata   = hit_ctrl ? ctrl_rd :
                       hit_cnt  ? cnt_q   :
                       hit_mcs2 ? mcs2_rd :
                       hit_pfs3 ? pfs3_rd :
                       hit_ists ? ists_rd :
                       hit_imsk ? imsk_rd :
                       8'h00;

  // ****************************************************************
  // Registers cleared by either reset source
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (chip_rst) begin
      cnt_wen_q  <= wdt_pkg::CTRL_RST[wdt_pkg::BIT_CNT_WEN];
      ctrl_wen_q <= wdt_pkg::CTRL_RST[wdt_pkg::BIT_CTRL_WEN];
      wd_on_q    <= wdt_pkg::CTRL_RST[wdt_pkg::BIT_WD_ON];
    end else begin
      if (cnt_wen_upd) begin
        cnt_wen_q <= wd[wdt_pkg::BIT_CNT_WEN];
      end
      if (ctrl_wen_upd) begin
        ctrl_wen_q <= wd[wdt_pkg::BIT_CTRL_WEN];
      end
      if (wd_on_upd) begin
        wd_on_q <= wd[wdt_pkg::BIT_WD_ON];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (chip_rst) begin
      cnt_q   <= wdt_pkg::CNT_RST;
      mstby_q <= wdt_pkg::MCS2_RST[wdt_pkg::BIT_MSTBY];
      cksel_q <= wdt_pkg::PFS3_RST[wdt_pkg::BIT_CKSEL];
    end else begin
      cnt_q <= cnt_d;
      if (wr & hit_mcs2) begin
        mstby_q <= wd[wdt_pkg::BIT_MSTBY];
      end
      if (wr & hit_pfs3) begin
        cksel_q <= wd[wdt_pkg::BIT_CKSEL];
      end
    end
  end

  // ****************************************************************
  // Registers cleared by the pin only
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q   <= wdt_pkg::WDT_IDLE;
      pcnt_q <= '0;
      flag_q <= wdt_pkg::CTRL_RST[wdt_pkg::BIT_FLAG];
      watchdog_reset_flag_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      pcnt_q <= pcnt_d;
      flag_q <= flag_d;
      watchdog_reset_flag_q <= (st_d == wdt_pkg::WDT_PULSE);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ists_q <= '0;
      imsk_q <= '0;
      irq_q  <= 1'b0;
    end else begin
      ists_q <= ists_d;
      imsk_q <= imsk_d;
      irq_q  <= |(ists_d & imsk_d);
    end
  end

  // ****************************************************************
  // Bus answer
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req;
      if (rd) begin
        dat_q <= {24'h00_0000, rdata};
      end
    end
  end

  // ****************************************************************
  // Outputs, all straight from flip-flops
  // ****************************************************************
  // Registered so that the pulse never glitches across the chip
  assign dat_o     = dat_q;
  assign ack_o     = ack_q;
  assign wdt_rst_o = watchdog_reset_flag_q;
  assign irq_o     = irq_q;

endmodule // wdt_top

// >>> src/wdt_pkg.sv
// Shared constants for the watchdog reset timer
package wdt_pkg;

  // ****************************************************************
  // Register byte offsets on the bus
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CNT  = 8'h04;
  localparam logic [7:0] OFS_MCS2 = 8'h08;
  localparam logic [7:0] OFS_PFS3 = 8'h0c;
  localparam logic [7:0] OFS_ISTS = 8'h10;
  localparam logic [7:0] OFS_IMSK = 8'h14;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned BIT_CNT_WEN_INH  = 7;
  localparam int unsigned BIT_CNT_WEN      = 6;
  localparam int unsigned BIT_CTRL_WEN_INH = 5;
  localparam int unsigned BIT_CTRL_WEN     = 4;
  localparam int unsigned BIT_WD_ON_INH    = 3;
  localparam int unsigned BIT_WD_ON        = 2;
  localparam int unsigned BIT_FLAG_INH     = 1;
  localparam int unsigned BIT_FLAG         = 0;
  localparam int unsigned BIT_MSTBY        = 2;
  localparam int unsigned BIT_CKSEL        = 5;
  localparam int unsigned IRQ_W            = 2;
  localparam int unsigned IRQ_OVF          = 0;
  localparam int unsigned IRQ_CNT_REJ      = 1;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] CTRL_RST = 8'haa;
  localparam logic [7:0] CNT_RST  = 8'h00;
  localparam logic [7:0] MCS2_RST = 8'hff;
  localparam logic [7:0] PFS3_RST = 8'h00;

  // ****************************************************************
  // Timing counts
  // ****************************************************************
  localparam int unsigned SYS_DIV_DEF    = 8192;
  localparam int unsigned SUB_DIV_DEF    = 32;
  localparam int unsigned RST_CYCLES_DEF = 512;

  // ****************************************************************
  // Operating modes on the power mode input
  // ****************************************************************
  localparam logic [2:0] PM_ACTIVE   = 3'h0;
  localparam logic [2:0] PM_SLEEP    = 3'h1;
  localparam logic [2:0] PM_WATCH    = 3'h2;
  localparam logic [2:0] PM_SUBACT   = 3'h3;
  localparam logic [2:0] PM_SUBSLEEP = 3'h4;
  localparam logic [2:0] PM_STANDBY  = 3'h5;

  // Reset generator states, Gray along idle-wait-pulse
  typedef enum logic [1:0] {
    WDT_IDLE  = 2'b00,
    WDT_WAIT  = 2'b01,
    WDT_PULSE = 2'b11
  } wdt_state_e;

endpackage

// >>> src/wdt_prescaler.sv
// Tick divider for the watchdog count clock
`timescale 1ns/10ps
module wdt_prescaler #(
  parameter int unsigned DIV = 32
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Source ticks and divided tick
  input  wire logic tick_i,
  output logic      tick_o
);

  localparam int unsigned CW = (DIV < 2) ? 1 : $clog2(DIV);

  generate
    if (DIV < 2) begin : g_bad_div
      $error("wdt_prescaler: DIV must be at least 2");
    end
  endgenerate

  logic [CW-1:0] cnt_q;
  logic          tick_q;
  wire           last = (cnt_q == CW'(DIV - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= tick_i & last;
      if (tick_i) begin
        cnt_q <= last ? '0 : cnt_q + CW'(1);
      end
    end
  end

  assign tick_o = tick_q;

endmodule // wdt_prescaler

// >>> dv/wdt_properties.sv
// Port-level checker for the watchdog reset timer
`timescale 1ns/10ps
module wdt_props_chk #(
  parameter int unsigned SYS_DIV    = 8192,
  parameter int unsigned SUB_DIV    = 32,
  parameter int unsigned RST_CYCLES = 512
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Ticks and mode
  input  wire logic        sub_tick_i,
  input  wire logic        osc_tick_i,
  input  wire logic [2:0]  pmode_i,
  // Bus
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  input  wire logic [31:0] dat_o,
  input  wire logic        ack_o,
  // Outputs
  input  wire logic        wdt_rst_o,
  input  wire logic        irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ****************************************************************
  // Oscillator pulses seen during the chip reset
  // ****************************************************************
  logic [15:0] osc_cnt_q;
  logic [15:0] osc_cnt_d;
  logic        req_w;
  assign osc_cnt_d = wdt_rst_o ? osc_cnt_q + {15'h0, osc_tick_i} : 16'h0;
  assign req_w     = cyc_i && stb_i && !ack_o;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_cnt_q <= 16'h0;
    end else begin
      osc_cnt_q <= osc_cnt_d;
    end
  end

  property p_ack_pulse;
    ack_o |=> !ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_ack_resp;
    req_w |=> ack_o;
  endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("no ack");
  property p_ack_cause;
    ack_o |-> $past(cyc_i && stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
  property p_rst_quiet;
    $fell(rst_i) |-> !wdt_rst_o && !irq_o && !ack_o;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("not quiet");
  property p_inh_read;
    req_w && !we_i && adr_i[7:2] == wdt_pkg::OFS_CTRL[7:2]
      |=> dat_o[7] && dat_o[5] && dat_o[3] && dat_o[1];
  endproperty
  a_inh_read: assert property (p_inh_read) else $error("inhibit bit 0");
  property p_unmapped;
    req_w && !we_i && adr_i[7:2] > wdt_pkg::OFS_IMSK[7:2] |=> dat_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped data");
  property p_rst_bound;
    wdt_rst_o |-> osc_cnt_q <= RST_CYCLES;
  endproperty
  a_rst_bound: assert property (p_rst_bound) else $error("pulse long");
  property p_rst_len;
    $fell(wdt_rst_o) && !$past(rst_i)
      |-> ($past(osc_cnt_q) + $past(osc_tick_i)) == RST_CYCLES;
  endproperty
  a_rst_len: assert property (p_rst_len) else $error("pulse short");
endmodule // wdt_props_chk

bind wdt_top wdt_props_chk #(
  .SYS_DIV(SYS_DIV), .SUB_DIV(SUB_DIV), .RST_CYCLES(RST_CYCLES)
) i_chk (
  .clk_i(clk_i), .rst_i(rst_i), .sub_tick_i(sub_tick_i),
  .osc_tick_i(osc_tick_i), .pmode_i(pmode_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
  .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .wdt_rst_o(wdt_rst_o),
  .irq_o(irq_o)
);

// >>> dv/wdt_tb.sv
// Self-checking bench for the watchdog reset timer
`timescale 1ns/10ps
module tb;
  logic        clk_i;
  logic        rst_i;
  logic        sub_tick_i;
  logic        osc_tick_i;
  logic [2:0]  pmode_i;
  logic        cyc_i;
  logic        stb_i;
  logic        we_i;
  logic [7:0]  adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        wdt_rst_o;
  logic        irq_o;
  logic [7:0]  rd_q;
  logic [7:0]  v;
  logic [3:0]  sub_div_q;
  logic [1:0]  osc_div_q;
  int          err_count;
  int          cmp_count;
  int          n;
  int          i;
  localparam logic [2:0] HALT_MODES [4] = '{wdt_pkg::PM_WATCH,
    wdt_pkg::PM_SUBACT, wdt_pkg::PM_SUBSLEEP, wdt_pkg::PM_STANDBY};

  wdt_top #(.SYS_DIV(4), .SUB_DIV(2), .RST_CYCLES(3)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .sub_tick_i(sub_tick_i),
    .osc_tick_i(osc_tick_i), .pmode_i(pmode_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .wdt_rst_o(wdt_rst_o),
    .irq_o(irq_o)
  );

  // ****************************************************************
  // Clock and reference tick pulses
  // ****************************************************************
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    sub_div_q  <= (sub_div_q == 4'h4) ? 4'h0 : sub_div_q + 4'h1;
    osc_div_q  <= (osc_div_q == 2'h2) ? 2'h0 : osc_div_q + 2'h1;
    sub_tick_i <= (sub_div_q == 4'h4);
    osc_tick_i <= (osc_div_q == 2'h2);
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic close_out();
    if (err_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 20);
    if (k >= 20) begin
      err_count++;
      close_out();
    end
    rd_q = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    check({24'h0, rd_q}, {24'h0, e});
  endtask
  task automatic wait_lvl(input logic lv, output int cnt);
    cnt = 0;
    while (wdt_rst_o !== lv && cnt < 300) begin
      @(posedge clk_i);
      cnt++;
    end
    if (cnt >= 300) begin
      err_count++;
      close_out();
    end
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {rst_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = {4'h8, 8'h0, 4'hf, 32'h0};
    {sub_tick_i, osc_tick_i, sub_div_q, osc_div_q} = 8'h0;
    pmode_i   = wdt_pkg::PM_ACTIVE;
    err_count = 0;
    cmp_count = 0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(wdt_pkg::OFS_CTRL, wdt_pkg::CTRL_RST);
    rd_chk(wdt_pkg::OFS_CNT, 8'h00);
    rd_chk(wdt_pkg::OFS_MCS2, 8'hff);
    rd_chk(wdt_pkg::OFS_PFS3, 8'h00);
    rd_chk(8'h40, 8'h00);
    // Refused counter write, interrupt enabled in mask
    bus(1'b1, wdt_pkg::OFS_IMSK, 8'h02);
    bus(1'b1, wdt_pkg::OFS_CNT, 8'h55);
    @(posedge clk_i);
    check({31'h0, irq_o}, 32'h1);
    rd_chk(wdt_pkg::OFS_CNT, 8'h00);
    rd_chk(wdt_pkg::OFS_ISTS, 8'h02);
    @(posedge clk_i);
    check({31'h0, irq_o}, 32'h0);
    rd_chk(wdt_pkg::OFS_ISTS, 8'h00);
    // Guarded control writes
    bus(1'b1, wdt_pkg::OFS_CTRL, 8'hff);
    rd_chk(wdt_pkg::OFS_CTRL, 8'haa);
    bus(1'b1, wdt_pkg::OFS_CTRL, 8'h14);
    rd_chk(wdt_pkg::OFS_CTRL, 8'hba);
    bus(1'b1, wdt_pkg::OFS_CTRL, 8'h50);
    bus(1'b1, wdt_pkg::OFS_CNT, 8'h10);
    repeat (20) @(posedge clk_i);
    rd_chk(wdt_pkg::OFS_CNT, 8'h10);
    bus(1'b1, wdt_pkg::OFS_CTRL, 8'ha6);
    rd_chk(wdt_pkg::OFS_CTRL, 8'hfe);
    bus(1'b0, wdt_pkg::OFS_CNT, 8'h00);
    v = rd_q;
    repeat (20) @(posedge clk_i);
    bus(1'b0, wdt_pkg::OFS_CNT, 8'h00);
    check({31'h0, rd_q > v}, 32'h1);
    // Halting modes, subactive on the system clock included
    for (i = 0; i < 4; i++) begin
      pmode_i <= HALT_MODES[i];
      bus(1'b0, wdt_pkg::OFS_CNT, 8'h00);
      v = rd_q;
      repeat (20) @(posedge clk_i);
      rd_chk(wdt_pkg::OFS_CNT, v);
    end
    pmode_i <= wdt_pkg::PM_ACTIVE;
    // Standby written while running is stored only
    bus(1'b1, wdt_pkg::OFS_MCS2, 8'hfb);
    rd_chk(wdt_pkg::OFS_MCS2, 8'hfb);
    v = rd_q;
    bus(1'b0, wdt_pkg::OFS_CNT, 8'h00);
    v = rd_q;
    repeat (20) @(posedge clk_i);
    bus(1'b0, wdt_pkg::OFS_CNT, 8'h00);
    check({31'h0, rd_q > v}, 32'h1);
    // One-tick overflow period
    bus(1'b1, wdt_pkg::OFS_CNT, 8'hff);
    wait_lvl(1'b1, n);
    check({31'h0, n < 8}, 32'h1);
    wait_lvl(1'b0, n);
    check({31'h0, n >= 6 && n <= 12}, 32'h1);
    rd_chk(wdt_pkg::OFS_CTRL, 8'hab);
    rd_chk(wdt_pkg::OFS_CNT, 8'h00);
    rd_chk(wdt_pkg::OFS_ISTS, 8'h01);
    // Flag cleared by guarded zero write
    bus(1'b1, wdt_pkg::OFS_CTRL, 8'h9a);
    rd_chk(wdt_pkg::OFS_CTRL, 8'hbb);
    bus(1'b1, wdt_pkg::OFS_CTRL, 8'ha8);
    rd_chk(wdt_pkg::OFS_CTRL, 8'hba);
    // Sub clock source is slower
    bus(1'b1, wdt_pkg::OFS_PFS3, 8'h20);
    rd_chk(wdt_pkg::OFS_PFS3, 8'h20);
    bus(1'b1, wdt_pkg::OFS_CTRL, 8'h50);
    bus(1'b1, wdt_pkg::OFS_CNT, 8'hfe);
    bus(1'b1, wdt_pkg::OFS_CTRL, 8'ha6);
    wait_lvl(1'b1, n);
    check({31'h0, n >= 12}, 32'h1);
    // Pin reset in mid-pulse clears the flag
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(wdt_pkg::OFS_CTRL, 8'haa);
    close_out();
  end
endmodule // tb
